// *** verilog/dicr_map.svh ***
// Constants for the digital input conditioning and routing block
`ifndef DICR_MAP_SVH
`define DICR_MAP_SVH

// Object access addresses
`define DICR_ADDR_SF_ENABLE 8'h01
`define DICR_ADDR_POL_INVERT 8'h02
`define DICR_ADDR_FORCE_EN 8'h03
`define DICR_ADDR_FORCE_VAL 8'h04
`define DICR_ADDR_RAW_VALUE 8'h05
`define DICR_ADDR_THRESH_SEL 8'h06
`define DICR_ADDR_DIFF_SEL 8'h07
`define DICR_ADDR_ROUTE_EN 8'h08
`define DICR_ADDR_INPUTS_WORD 8'h10
// Routing entry k (1..32) sits at base + k
`define DICR_ADDR_ROUTE_BASE 8'h40
`define DICR_ADDR_ROUTE_FIRST 8'h41
`define DICR_ADDR_ROUTE_LAST 8'h60

// Field positions in the digital inputs word
`define DICR_BIT_NEG_LIMIT 0
`define DICR_BIT_POS_LIMIT 1
`define DICR_BIT_HOME 2
`define DICR_LEVEL_BASE 16

// Input counts
`define DICR_NUM_INPUTS 6
`define DICR_NUM_SPECIAL 3
`define DICR_NUM_DIFF 3
`define DICR_NUM_SOURCES 16
`define DICR_WORD_BITS 32

// Routing source codes
`define DICR_SRC_CONST0 8'h00
`define DICR_SRC_LAST 7'h10
`define DICR_SRC_INV_FLAG 7

// Reset values
`define DICR_RST_WORD 32'h0000_0000
`define DICR_RST_CODE 8'h00

// Timing
`define DICR_SAMPLE_TIME_MS 1
`define DICR_CLK_FREQ_KHZ 100000

`endif

// *** verilog/dicr_pkg.sv ***
// Types for the digital input conditioning and routing block
`default_nettype none
package dicr_pkg;
  typedef logic [7:0] dicr_code_t;
  typedef logic [7:0] dicr_addr_t;
  typedef logic [31:0] dicr_word_t;
  typedef logic [5:0] dicr_inputs_t;
  typedef logic [15:0] dicr_sources_t;
endpackage : dicr_pkg
`default_nettype wire

// *** verilog/dicr_route_sel.sv ***
// One routing selector: source code to one bit of the inputs word
`timescale 1ns/1ps
`default_nettype none
`include "dicr_map.svh"
module dicr_route_sel (
  input wire dicr_pkg::dicr_code_t code_in,
  input wire dicr_pkg::dicr_sources_t src_in,
  output logic bit_out
);
  import dicr_pkg::*;

  // Code split into invert flag and source number
  logic invert;
  logic [6:0] src_num;
  logic [6:0] src_idx;
  logic in_range;
  logic picked;
  assign invert = code_in[`DICR_SRC_INV_FLAG];
  assign src_num = code_in[6:0];
  assign src_idx = src_num - 7'h01;
  assign in_range = (src_num <= `DICR_SRC_LAST);
  // Number 0 gives constant, 1..16 pick bit 0..15 of src_in
  assign picked = (src_num == 7'h00) ? 1'b0 : src_in[src_idx[3:0]];
  // Reserved codes read as 0, invert flag flips the rest
  assign bit_out = in_range ? (picked ^ invert) : 1'b0;
endmodule : dicr_route_sel
`default_nettype wire

// *** verilog/dicr_top.sv ***
// Digital input conditioning, special functions and input routing
//
// Contract
// - Sample inputs each millisecond, reject shorter pulses
// - Special-function results sit in bits 0-15
// - Input n level appears at bit 15+n
// - Input 1 level shown regardless of function
// - Enable bits gate limit and home functions
// - Inputs 2,3 give direction and clock
// - Per-input polarity inversion, not clock/direction
// - Force enable replaces sampled input value
// - Force value bit supplies forced input value
// - Raw value shows unmodified sampled pins
// - Range bit drives 5 V/24 V threshold
// - One differential select for all inputs
// - Routing enable switches table onto word
// - Enabling routing preloads equivalent table entries
// - Table entry k feeds word bit k-1
// - Code 0 constant zero, 1-16 inputs
// - Code 80 constant one, 81-90 inverted
`timescale 1ns/1ps
`default_nettype none
`include "dicr_map.svh"
module dicr_top #(
  parameter int unsigned SAMPLE_TICK_CYCLES = `DICR_SAMPLE_TIME_MS * `DICR_CLK_FREQ_KHZ
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire dicr_pkg::dicr_inputs_t pin_in,
  input wire logic clk_dir_mode_in,
  input wire dicr_pkg::dicr_addr_t od_addr_in,
  input wire logic od_wr_in,
  input wire logic od_rd_in,
  input wire dicr_pkg::dicr_word_t od_wdata_in,
  output dicr_pkg::dicr_word_t od_rdata_out,
  output logic od_ack_out,
  output dicr_pkg::dicr_word_t inputs_word_out,
  output dicr_pkg::dicr_inputs_t threshold_sel_out,
  output logic diff_sel_out,
  output logic step_clk_out,
  output logic step_dir_out
);
  import dicr_pkg::*;

  localparam int unsigned CW = (SAMPLE_TICK_CYCLES > 1) ? $clog2(SAMPLE_TICK_CYCLES) : 1;
  localparam logic [CW-1:0] TICK_LAST = CW'(SAMPLE_TICK_CYCLES - 1);

  // Pin synchronisers
  dicr_inputs_t pin_meta_r;
  dicr_inputs_t pin_sync_r;
  always_ff @(posedge clk_in) begin
    pin_meta_r <= pin_in;
    pin_sync_r <= pin_meta_r;
  end

  // Millisecond tick divider
  logic [CW-1:0] tick_cnt_r;
  logic tick_r;
  logic publish_r;
  logic tick_wrap;
  logic [CW-1:0] tick_cnt_nxt;
  assign tick_wrap = (tick_cnt_r == TICK_LAST);
  assign tick_cnt_nxt = tick_wrap ? '0 : tick_cnt_r + 1'b1;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
      publish_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_wrap;
      publish_r <= tick_r;
    end
  end

  // Configuration registers
  logic [2:0] sf_enable_r;
  dicr_inputs_t pol_invert_r;
  dicr_inputs_t force_en_r;
  dicr_inputs_t force_val_r;
  dicr_inputs_t thresh_sel_r;
  logic diff_sel_r;
  logic route_en_r;

  // Address decode for the read multiplexer
  logic sel_sf;
  logic sel_inv;
  logic sel_fen;
  logic sel_fval;
  logic sel_raw;
  logic sel_thr;
  logic sel_diff;
  logic sel_ren;
  logic sel_word;
  assign sel_sf = (od_addr_in == `DICR_ADDR_SF_ENABLE);
  assign sel_inv = (od_addr_in == `DICR_ADDR_POL_INVERT);
  assign sel_fen = (od_addr_in == `DICR_ADDR_FORCE_EN);
  assign sel_fval = (od_addr_in == `DICR_ADDR_FORCE_VAL);
  assign sel_raw = (od_addr_in == `DICR_ADDR_RAW_VALUE);
  assign sel_thr = (od_addr_in == `DICR_ADDR_THRESH_SEL);
  assign sel_diff = (od_addr_in == `DICR_ADDR_DIFF_SEL);
  assign sel_ren = (od_addr_in == `DICR_ADDR_ROUTE_EN);
  assign sel_word = (od_addr_in == `DICR_ADDR_INPUTS_WORD);

  // Write decode
  logic wr_sf;
  logic wr_inv;
  logic wr_fen;
  logic wr_fval;
  logic wr_thr;
  logic wr_diff;
  logic wr_ren;
  logic route_turn_on;
  logic tbl_hit;
  logic [7:0] tbl_off;
  logic [4:0] tbl_idx;
  assign wr_sf = od_wr_in && (od_addr_in == `DICR_ADDR_SF_ENABLE);
  assign wr_inv = od_wr_in && (od_addr_in == `DICR_ADDR_POL_INVERT);
  assign wr_fen = od_wr_in && (od_addr_in == `DICR_ADDR_FORCE_EN);
  assign wr_fval = od_wr_in && (od_addr_in == `DICR_ADDR_FORCE_VAL);
  assign wr_thr = od_wr_in && (od_addr_in == `DICR_ADDR_THRESH_SEL);
  assign wr_diff = od_wr_in && (od_addr_in == `DICR_ADDR_DIFF_SEL);
  assign wr_ren = od_wr_in && (od_addr_in == `DICR_ADDR_ROUTE_EN);
  assign route_turn_on = wr_ren && od_wdata_in[0] && !route_en_r;
  assign tbl_hit = (od_addr_in >= `DICR_ADDR_ROUTE_FIRST) && (od_addr_in <= `DICR_ADDR_ROUTE_LAST);
  assign tbl_off = od_addr_in - `DICR_ADDR_ROUTE_FIRST;
  assign tbl_idx = tbl_off[4:0];

  // Table write port
  logic tbl_wr_any;
  dicr_code_t tbl_wdata;
  assign tbl_wr_any = od_wr_in && tbl_hit;
  assign tbl_wdata = od_wdata_in[7:0];

  // Configuration register updates
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sf_enable_r <= '0;
      pol_invert_r <= '0;
      force_en_r <= '0;
      force_val_r <= '0;
      thresh_sel_r <= '0;
      diff_sel_r <= 1'b0;
      route_en_r <= 1'b0;
    end else begin
      if (wr_sf) sf_enable_r <= od_wdata_in[2:0];
      if (wr_inv) pol_invert_r <= od_wdata_in[5:0];
      if (wr_fen) force_en_r <= od_wdata_in[5:0];
      if (wr_fval) force_val_r <= od_wdata_in[5:0];
      if (wr_thr) thresh_sel_r <= od_wdata_in[5:0];
      if (wr_diff) diff_sel_r <= od_wdata_in[0];
      if (wr_ren) route_en_r <= od_wdata_in[0];
    end
  end

  // Differential mode leaves only three inputs
  dicr_inputs_t diff_mask;
  dicr_inputs_t pin_eff;
  assign diff_mask = diff_sel_r ? 6'h07 : 6'h3f;
  assign pin_eff = pin_sync_r & diff_mask;

  // Two-tick agreement filter and raw capture
  dicr_inputs_t prev_samp_r;
  dicr_inputs_t raw_r;
  dicr_inputs_t raw_nxt;
  dicr_inputs_t samp_agree;
  // A bit moves only when two ticks agree, else the old raw bit holds
  assign samp_agree = ~(pin_eff ^ prev_samp_r);
  assign raw_nxt = (pin_eff & samp_agree) | (raw_r & ~samp_agree);
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      prev_samp_r <= '0;
      raw_r <= '0;
    end else if (tick_r) begin
      prev_samp_r <= pin_eff;
      raw_r <= raw_nxt;
    end
  end

  // Force substitution, then polarity inversion
  dicr_inputs_t forced;
  dicr_inputs_t cond;
  logic [2:0] special;
  assign forced = (force_en_r & force_val_r) | (~force_en_r & raw_r);
  assign cond = forced ^ pol_invert_r;
  assign special = cond[2:0] & sf_enable_r;

  // Normal-mode word: specials low, levels high
  dicr_word_t normal_word;
  logic [15:0] level_half;
  logic [15:0] special_half;
  assign level_half = {10'h000, cond};
  assign special_half = {13'h0000, special};
  assign normal_word = {level_half, special_half};

  // Routing sources: conditioned inputs 1..6, sources 7..16 read zero
  dicr_sources_t sources;
  assign sources = {10'h000, cond};

  // Routing table storage with preload on enable
  dicr_code_t tbl_r [`DICR_WORD_BITS];
  dicr_word_t routed_word;
  genvar k;
  generate
    for (k = 0; k < `DICR_WORD_BITS; k = k + 1) begin : g_route
      dicr_code_t preload;
      logic tbl_wr;
      if (k < `DICR_NUM_SPECIAL) begin : g_sp
        assign preload = sf_enable_r[k] ? 8'(k + 1) : `DICR_SRC_CONST0;
      end else if ((k >= `DICR_LEVEL_BASE) && (k < `DICR_LEVEL_BASE + `DICR_NUM_INPUTS)) begin : g_lv
        assign preload = 8'(k - `DICR_LEVEL_BASE + 1);
      end else begin : g_zero
        assign preload = `DICR_SRC_CONST0;
      end
      assign tbl_wr = tbl_wr_any && (tbl_idx == 5'(k));
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          tbl_r[k] <= `DICR_RST_CODE;
        end else if (route_turn_on) begin
          tbl_r[k] <= preload;
        end else if (tbl_wr) begin
          tbl_r[k] <= tbl_wdata;
        end
      end
      dicr_route_sel u_sel (
        .code_in(tbl_r[k]),
        .src_in(sources),
        .bit_out(routed_word[k])
      );
    end
  endgenerate

  // Publish word one cycle after each sample tick
  dicr_word_t word_nxt;
  assign word_nxt = route_en_r ? routed_word : normal_word;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      inputs_word_out <= `DICR_RST_WORD;
    end else if (publish_r) begin
      inputs_word_out <= word_nxt;
    end
  end

  // Clock on pin 3, direction on pin 2, straight from the synchroniser
  logic step_clk_nxt;
  logic step_dir_nxt;
  assign step_clk_nxt = clk_dir_mode_in & pin_sync_r[2];
  assign step_dir_nxt = clk_dir_mode_in & pin_sync_r[1];

  // Clock-direction pins bypass the filter and inversion
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      step_clk_out <= 1'b0;
      step_dir_out <= 1'b0;
    end else begin
      step_clk_out <= step_clk_nxt;
      step_dir_out <= step_dir_nxt;
    end
  end

  // Front-end selects
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      threshold_sel_out <= '0;
      diff_sel_out <= 1'b0;
    end else begin
      threshold_sel_out <= thresh_sel_r;
      diff_sel_out <= diff_sel_r;
    end
  end

  // Read multiplexer, unmapped places read zero
  dicr_word_t tbl_rd_word;
  dicr_word_t rd_nxt;
  assign tbl_rd_word = {24'h0, tbl_r[tbl_idx]};
  assign rd_nxt =
    sel_sf ? {29'h0, sf_enable_r} :
    sel_inv ? {26'h0, pol_invert_r} :
    sel_fen ? {26'h0, force_en_r} :
    sel_fval ? {26'h0, force_val_r} :
    sel_raw ? {26'h0, raw_r} :
    sel_thr ? {26'h0, thresh_sel_r} :
    sel_diff ? {31'h0, diff_sel_r} :
    sel_ren ? {31'h0, route_en_r} :
    sel_word ? inputs_word_out :
    tbl_hit ? tbl_rd_word : `DICR_RST_WORD;

  // Every strobe is answered, even to a refused place
  logic od_req;
  assign od_req = od_wr_in | od_rd_in;

  // Access answer, one cycle after request
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      od_rdata_out <= `DICR_RST_WORD;
      od_ack_out <= 1'b0;
    end else begin
      od_ack_out <= od_req;
      if (od_rd_in) od_rdata_out <= rd_nxt;
    end
  end
endmodule : dicr_top
`default_nettype wire

// *** verification/dicr_pins_model.sv ***
// Switch and signal source model driving the input pins
`timescale 1ns/1ps
`default_nettype none
module dicr_pins_model (
  input wire dicr_pkg::dicr_inputs_t level_in,
  input wire dicr_pkg::dicr_inputs_t glitch_in,
  output wire dicr_pkg::dicr_inputs_t pin_out
);
  import dicr_pkg::*;
  // Steady switch level with short pulses laid over it
  assign pin_out = level_in ^ glitch_in;
endmodule : dicr_pins_model
`default_nettype wire

// *** verification/dicr_top_monitor.sv ***
// Port checker for the input conditioning block
`timescale 1ns/1ps
`default_nettype none
module dicr_top_monitor #(
  parameter int unsigned SAMPLE_TICK_CYCLES = 8
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clk_dir_mode_in,
  input wire dicr_pkg::dicr_addr_t od_addr_in,
  input wire logic od_wr_in,
  input wire logic od_rd_in,
  input wire dicr_pkg::dicr_word_t od_wdata_in,
  input wire dicr_pkg::dicr_word_t od_rdata_out,
  input wire logic od_ack_out,
  input wire dicr_pkg::dicr_word_t inputs_word_out,
  input wire dicr_pkg::dicr_inputs_t threshold_sel_out,
  input wire logic diff_sel_out,
  input wire logic step_clk_out,
  input wire logic step_dir_out
);
  import dicr_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic route_on_r;
  // Tracks routing mode from enable writes
  always_ff @(posedge clk_in) begin
    if (reset_in) route_on_r <= 1'b0;
    else if (od_wr_in && od_addr_in == 8'h08) route_on_r <= od_wdata_in[0];
  end
  property p_thr_wr;
    od_wr_in && od_addr_in == 8'h06 |-> ##2 threshold_sel_out == $past(od_wdata_in[5:0], 2);
  endproperty
  a_thr_wr: assert property (p_thr_wr)
    else $error("threshold select not loaded");
  property p_thr_rd;
    od_rd_in && !od_wr_in && od_addr_in == 8'h06 |=>
      od_ack_out && od_rdata_out == {26'h0, threshold_sel_out};
  endproperty
  a_thr_rd: assert property (p_thr_rd)
    else $error("threshold readback wrong");
  property p_diff;
    od_wr_in && od_addr_in == 8'h07 |-> ##2 diff_sel_out == $past(od_wdata_in[0], 2);
  endproperty
  a_diff: assert property (p_diff)
    else $error("differential select not loaded");
  property p_step_off;
    !clk_dir_mode_in |=> !step_clk_out && !step_dir_out;
  endproperty
  a_step_off: assert property (p_step_off)
    else $error("step outputs active outside mode");
  property p_sf_gate;
    !route_on_r |-> (inputs_word_out[2:0] & ~inputs_word_out[18:16]) == 3'h0;
  endproperty
  a_sf_gate: assert property (p_sf_gate)
    else $error("special bit without level bit");
  property p_zero;
    !route_on_r |-> inputs_word_out[15:3] == 13'h0 && inputs_word_out[31:22] == 10'h0;
  endproperty
  a_zero: assert property (p_zero)
    else $error("unused word bits set");
  // Repeat count matches a tick of 8 cycles
  property p_hold;
    $changed(inputs_word_out) |=> $stable(inputs_word_out) [*7];
  endproperty
  a_hold: assert property (p_hold)
    else $error("word changed between ticks");
  property p_word_rd;
    od_rd_in && !od_wr_in && od_addr_in == 8'h10 |=> od_rdata_out == $past(inputs_word_out);
  endproperty
  a_word_rd: assert property (p_word_rd)
    else $error("word readback wrong");
endmodule : dicr_top_monitor
bind dicr_top dicr_top_monitor #(.SAMPLE_TICK_CYCLES(SAMPLE_TICK_CYCLES)) u_dicr_top_monitor (
  .clk_in(clk_in), .reset_in(reset_in), .clk_dir_mode_in(clk_dir_mode_in),
  .od_addr_in(od_addr_in), .od_wr_in(od_wr_in), .od_rd_in(od_rd_in),
  .od_wdata_in(od_wdata_in), .od_rdata_out(od_rdata_out), .od_ack_out(od_ack_out),
  .inputs_word_out(inputs_word_out), .threshold_sel_out(threshold_sel_out),
  .diff_sel_out(diff_sel_out), .step_clk_out(step_clk_out), .step_dir_out(step_dir_out)
);
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the input conditioning block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dicr_pkg::*;
  localparam int unsigned TICK = 8;
  typedef struct packed {
    logic [5:0] pins;
    logic [5:0] inv;
    logic [5:0] fen;
    logic [5:0] fval;
    logic [2:0] sf;
    logic [31:0] word;
  } dicr_row_s;
  // Pins, invert, force enable, force value, special enable, word
  dicr_row_s rows [5] = '{
    '{6'h2d, 6'h00, 6'h00, 6'h00, 3'h7, 32'h002d_0005},
    '{6'h2d, 6'h3f, 6'h00, 6'h00, 3'h7, 32'h0012_0002},
    '{6'h2d, 6'h00, 6'h03, 6'h02, 3'h3, 32'h002e_0002},
    '{6'h3e, 6'h01, 6'h01, 6'h01, 3'h1, 32'h003e_0000},
    '{6'h07, 6'h00, 6'h00, 6'h00, 3'h0, 32'h0007_0000}};
  dicr_addr_t rt_addr [9] = '{8'h41, 8'h58, 8'h59, 8'h5a, 8'h5b, 8'h5c, 8'h5d, 8'h5e, 8'h5f};
  dicr_code_t rt_code [9] = '{8'h00, 8'h80, 8'h81, 8'h82, 8'h11, 8'h02, 8'h90, 8'h03, 8'h10};
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic clk_dir_mode_in = 1'b0;
  logic od_wr_in = 1'b0;
  logic od_rd_in = 1'b0;
  dicr_addr_t od_addr_in = 8'h00;
  dicr_word_t od_wdata_in = 32'h0;
  dicr_inputs_t level = 6'h00;
  dicr_inputs_t glitch = 6'h00;
  dicr_inputs_t pin_in, threshold_sel_out;
  dicr_word_t od_rdata_out, inputs_word_out, rd_q;
  logic od_ack_out, diff_sel_out, step_clk_out, step_dir_out;
  int bad_count = 0;
  int check_count = 0;
  // Free-running 100 MHz clock
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  dicr_pins_model u_dicr_pins_model (.level_in(level), .glitch_in(glitch), .pin_out(pin_in));
  dicr_top #(.SAMPLE_TICK_CYCLES(TICK)) u_dicr_top (
    .clk_in(clk_in), .reset_in(reset_in), .pin_in(pin_in), .clk_dir_mode_in(clk_dir_mode_in),
    .od_addr_in(od_addr_in), .od_wr_in(od_wr_in), .od_rd_in(od_rd_in),
    .od_wdata_in(od_wdata_in), .od_rdata_out(od_rdata_out), .od_ack_out(od_ack_out),
    .inputs_word_out(inputs_word_out), .threshold_sel_out(threshold_sel_out),
    .diff_sel_out(diff_sel_out), .step_clk_out(step_clk_out), .step_dir_out(step_dir_out));
  task automatic chk(input dicr_word_t got, input dicr_word_t exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One strobe cycle, ack and read data one cycle later
  task automatic acc(input logic wr, input dicr_addr_t a, input dicr_word_t d);
    @(negedge clk_in);
    od_wr_in = wr;
    od_rd_in = !wr;
    od_addr_in = a;
    od_wdata_in = d;
    @(negedge clk_in);
    od_wr_in = 1'b0;
    od_rd_in = 1'b0;
    rd_q = od_rdata_out;
    chk({31'h0, od_ack_out}, 32'h1);
  endtask : acc
  // Long enough for sync, two matching ticks and a publish
  task automatic settle;
    repeat (4 * TICK) @(negedge clk_in);
  endtask : settle
  task automatic do_reset;
    reset_in = 1'b1;
    repeat (6) @(negedge clk_in);
    reset_in = 1'b0;
  endtask : do_reset
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  initial begin
    do_reset;
    // Configuration reads zero after reset
    for (int a = 1; a <= 8; a++) begin
      acc(1'b0, dicr_addr_t'(a), 32'h0);
      chk(rd_q, 32'h0);
    end
    // Conditioning table
    foreach (rows[i]) begin
      acc(1'b1, 8'h01, {29'h0, rows[i].sf});
      acc(1'b1, 8'h02, {26'h0, rows[i].inv});
      acc(1'b1, 8'h03, {26'h0, rows[i].fen});
      acc(1'b1, 8'h04, {26'h0, rows[i].fval});
      level = rows[i].pins;
      settle;
      chk(inputs_word_out, rows[i].word);
      acc(1'b0, 8'h10, 32'h0);
      chk(rd_q, rows[i].word);
      acc(1'b0, 8'h05, 32'h0);
      chk(rd_q, {26'h0, rows[i].pins});
    end
    // Short pulse, read-only and unmapped places
    glitch = 6'h08;
    repeat (3) @(negedge clk_in);
    glitch = 6'h00;
    acc(1'b1, 8'h05, 32'hffff_ffff);
    acc(1'b1, 8'h10, 32'hffff_ffff);
    settle;
    chk(inputs_word_out, 32'h0007_0000);
    acc(1'b0, 8'h05, 32'h0);
    chk(rd_q, 32'h7);
    acc(1'b0, 8'h20, 32'h0);
    chk(rd_q, 32'h0);
    // Threshold and differential selects
    acc(1'b1, 8'h06, 32'h15);
    @(negedge clk_in);
    chk({26'h0, threshold_sel_out}, 32'h15);
    acc(1'b0, 8'h06, 32'h0);
    chk(rd_q, 32'h15);
    acc(1'b1, 8'h07, 32'h1);
    level = 6'h3f;
    settle;
    chk({31'h0, diff_sel_out}, 32'h1);
    acc(1'b0, 8'h05, 32'h0);
    chk(rd_q, 32'h7);
    acc(1'b1, 8'h07, 32'h0);
    // Clock-direction ignores inversion
    acc(1'b1, 8'h02, 32'h3f);
    clk_dir_mode_in = 1'b1;
    level = 6'h06;
    settle;
    chk({30'h0, step_clk_out, step_dir_out}, 32'h3);
    chk(inputs_word_out, 32'h0039_0000);
    clk_dir_mode_in = 1'b0;
    acc(1'b1, 8'h02, 32'h0);
    // Routing keeps behaviour, then a custom table
    acc(1'b1, 8'h01, 32'h7);
    level = 6'h2d;
    acc(1'b1, 8'h08, 32'h1);
    settle;
    chk(inputs_word_out, 32'h002d_0005);
    acc(1'b0, 8'h51, 32'h0);
    chk(rd_q, 32'h1);
    foreach (rt_addr[i]) acc(1'b1, rt_addr[i], {24'h0, rt_code[i]});
    settle;
    chk(inputs_word_out, 32'h32ad_0004);
    acc(1'b0, 8'h58, 32'h0);
    chk(rd_q, 32'h80);
    // Second reset in mid-run
    do_reset;
    chk(inputs_word_out, 32'h0);
    chk({26'h0, threshold_sel_out}, 32'h0);
    acc(1'b0, 8'h08, 32'h0);
    chk(rd_q, 32'h0);
    print_verdict;
  end
endmodule : tb
`default_nettype wire
